// ### src/tpg_pkg.sv
// Behaviour
// - Enable bit 0 starts pattern output; clearing it stops output.
// - While enabled, only enable and error-inject registers accept writes.
// - First valid beat appears in the fourth cycle after enable sets.
// - On disable, final beat appears in the second cycle after, then output stops.
// - Select bit 0: 7-stage PN taps 7,6; bit 1: 15-stage taps 15,14.
// - Select bit 2: 23-stage PN taps 23,18; bit 3: 31-stage taps 31,28.
// - Select bit 4 outputs alternating zero-one pattern over the beat.
// - Select bit 5 outputs five ones/five zeros, or four/four for 8-bit.
// - Inject bit inserts one bit error; while enabled it clears itself next cycle.
// - Error inverts LSB of beat emitted four cycles after inject set.
// - Disabling within two cycles of inject may lose the corrupted beat.
// - Preamble enabled at start sends character count times, then pattern.
// - Preamble repeat count is 8-bit field at bits 15:8.
// - Preamble character bits 31:0 come from the low register.
// - Character bits 39:32 from high register 7:0; ignored for width 32.
// - Repeat count resets to 0, max 255; configured only while disabled.
// - Inject set before start puts the error in the first output beat.
`default_nettype none
package tpg_pkg;
    localparam logic [2:0] ADDR_ENABLE = 3'h0;
    localparam logic [2:0] ADDR_PATTERN = 3'h1;
    localparam logic [2:0] ADDR_INJECT = 3'h2;
    localparam logic [2:0] ADDR_PREAMBLE_CTRL = 3'h3;
    localparam logic [2:0] ADDR_CHAR_LOW = 3'h4;
    localparam logic [2:0] ADDR_CHAR_HIGH = 3'h5;
    localparam int BIT_ENABLE = 0;
    localparam int BIT_INJECT = 0;
    localparam int BIT_PREAMBLE_ON = 0;
    localparam int COUNT_LSB = 8;
    localparam int COUNT_W = 8;
    localparam int SEL_W = 6;
    localparam int SEL_PN7 = 0;
    localparam int SEL_PN15 = 1;
    localparam int SEL_PN23 = 2;
    localparam int SEL_PN31 = 3;
    localparam int SEL_HIGH_TOGGLE = 4;
    localparam int SEL_LOW_TOGGLE = 5;
    localparam int START_DELAY = 1;
    localparam int INJECT_DELAY = 1;
    localparam logic [30:0] PN_SEED = 31'h7FFFFFFF;

    typedef struct packed {
        logic write;
        logic read;
        logic [2:0] address;
        logic [31:0] write_data;
    } tpg_reg_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PREAMBLE = 3'b010,
        ST_PATTERN = 3'b100
    } tpg_state_t;
endpackage
`default_nettype wire

// ### src/tpg_fifo.sv
`default_nettype none
module tpg_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic push;
    logic pop;

    assign out_valid_o = wr_ptr_reg != rd_ptr_reg;
    assign in_ready_o = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ### src/tpg_top.sv
`default_nettype none
module tpg_top #(
    parameter int DATA_W = 40,
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Register port
    input wire tpg_pkg::tpg_reg_req_t reg_req_i,
    output logic [31:0] reg_read_data_o,
    // Stream source
    output logic src_valid_o,
    input wire logic src_ready_i,
    output logic [DATA_W-1:0] src_data_o
);
    localparam int SYM_W = (DATA_W % 10 == 0) ? 10 : 8;

    typedef struct packed {
        logic enable;
        logic [tpg_pkg::SEL_W-1:0] select;
        logic inject;
        logic preamble_on;
        logic [tpg_pkg::COUNT_W-1:0] count;
        logic [39:0] pre_char;
        tpg_pkg::tpg_state_t state;
        logic [1:0] start_cnt;
        logic [tpg_pkg::COUNT_W-1:0] pre_left;
        logic [30:0] pn;
        logic [3:0] inj_pipe;
        logic pend_err;
        logic [DATA_W-1:0] beat;
        logic beat_valid;
        logic [31:0] rdata;
    } tpg_state_all_t;

    tpg_state_all_t s_reg;
    tpg_state_all_t s_next;
    logic fifo_ready;

    // One parallel step of a two-tap sequence: new bit = s[a-1] ^ s[b-1]
    function automatic logic [30:0] pn_step(input logic [30:0] s, input int len,
                                            input int ta, input int tb);
        logic [30:0] r;
        logic fb;
        r = s;
        for (int i = 0; i < DATA_W; i++) begin
            fb = r[ta-1] ^ r[tb-1];
            r = {r[29:0], fb};
            r = r & ((31'h1 << len) - 31'h1);
        end
        return r;
    endfunction

    function automatic logic [DATA_W-1:0] pn_bits(input logic [30:0] s, input int len,
                                                  input int ta, input int tb);
        logic [30:0] r;
        logic [DATA_W-1:0] d;
        r = s;
        d = '0;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            d[i] = r[ta-1] ^ r[tb-1];
            r = {r[29:0], d[i]} & ((31'h1 << len) - 31'h1);
        end
        return d;
    endfunction

    function automatic logic [DATA_W-1:0] low_toggle();
        logic [DATA_W-1:0] d;
        for (int i = 0; i < DATA_W; i++) begin
            d[i] = ((i % SYM_W) >= SYM_W / 2);
        end
        return d;
    endfunction

    function automatic logic [DATA_W-1:0] high_toggle();
        logic [DATA_W-1:0] d;
        for (int i = 0; i < DATA_W; i++) begin
            d[i] = i[0];
        end
        return d;
    endfunction

    always_comb begin
        logic adv;
        logic [DATA_W-1:0] d;
        logic [30:0] pn_seed;
        adv = 1'b0;
        d = '0;
        pn_seed = tpg_pkg::PN_SEED;
        s_next = s_reg;
        // Register writes
        if (reg_req_i.write) begin
            case (reg_req_i.address)
                tpg_pkg::ADDR_ENABLE: begin
                    s_next.enable = reg_req_i.write_data[tpg_pkg::BIT_ENABLE];
                end
                tpg_pkg::ADDR_INJECT: begin
                    s_next.inject = reg_req_i.write_data[tpg_pkg::BIT_INJECT];
                end
                default: begin
                    if (!s_reg.enable) begin
                        case (reg_req_i.address)
                            tpg_pkg::ADDR_PATTERN: begin
                                s_next.select = reg_req_i.write_data[tpg_pkg::SEL_W-1:0];
                            end
                            tpg_pkg::ADDR_PREAMBLE_CTRL: begin
                                s_next.preamble_on =
                                    reg_req_i.write_data[tpg_pkg::BIT_PREAMBLE_ON];
                                s_next.count = reg_req_i.write_data[tpg_pkg::COUNT_LSB +:
                                    tpg_pkg::COUNT_W];
                            end
                            tpg_pkg::ADDR_CHAR_LOW: begin
                                s_next.pre_char[31:0] = reg_req_i.write_data;
                            end
                            tpg_pkg::ADDR_CHAR_HIGH: begin
                                s_next.pre_char[39:32] = reg_req_i.write_data[7:0];
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            endcase
        end
        // Read mux
        case (reg_req_i.address)
            tpg_pkg::ADDR_ENABLE: s_next.rdata = {31'h0, s_reg.enable};
            tpg_pkg::ADDR_PATTERN: s_next.rdata = {26'h0, s_reg.select};
            tpg_pkg::ADDR_INJECT: s_next.rdata = {31'h0, s_reg.inject};
            tpg_pkg::ADDR_PREAMBLE_CTRL: s_next.rdata = {16'h0, s_reg.count, 7'h0,
                                                         s_reg.preamble_on};
            tpg_pkg::ADDR_CHAR_LOW: s_next.rdata = s_reg.pre_char[31:0];
            tpg_pkg::ADDR_CHAR_HIGH: s_next.rdata = {24'h0, s_reg.pre_char[39:32]};
            default: s_next.rdata = 32'h0;
        endcase
        // Error inject pipeline: stage INJECT_DELAY-1 (stage 0) sets pend_err two cycles after the bit sets
        s_next.inj_pipe = {s_reg.inj_pipe[2:0], 1'b0};
        if (s_reg.inject && s_reg.enable && s_reg.state != tpg_pkg::ST_IDLE) begin
            s_next.inj_pipe[0] = 1'b1;
            s_next.inject = 1'b0;
        end
        if (s_reg.inj_pipe[tpg_pkg::INJECT_DELAY - 1]) begin
            s_next.pend_err = 1'b1;
        end
        // Beat leaves the output stage into the FIFO
        if (s_reg.beat_valid && fifo_ready) begin
            s_next.beat_valid = 1'b0;
        end
        adv = !s_next.beat_valid;
        case (s_reg.state)
            tpg_pkg::ST_IDLE: begin
                s_next.pn = pn_seed;
                if (s_reg.enable) begin
                    s_next.start_cnt = s_reg.start_cnt + 2'h1;
                    if (s_reg.start_cnt == 2'(tpg_pkg::START_DELAY - 1)) begin
                        s_next.start_cnt = 2'h0;
                        s_next.pre_left = s_reg.count;
                        s_next.state = (s_reg.preamble_on && s_reg.count != 8'h0) ?
                            tpg_pkg::ST_PREAMBLE : tpg_pkg::ST_PATTERN;
                        if (s_reg.inject) begin
                            s_next.pend_err = 1'b1;
                            s_next.inject = 1'b0;
                        end
                    end
                end else begin
                    s_next.start_cnt = 2'h0;
                end
            end
            tpg_pkg::ST_PREAMBLE: begin
                if (!s_reg.enable) begin
                    s_next.state = tpg_pkg::ST_IDLE;
                end else if (adv) begin
                    d = s_reg.pre_char[DATA_W > 40 ? 39 : DATA_W - 1:0];
                    s_next.pre_left = s_reg.pre_left - 8'h1;
                    if (s_reg.pre_left == 8'h1) begin
                        s_next.state = tpg_pkg::ST_PATTERN;
                    end
                end
            end
            tpg_pkg::ST_PATTERN: begin
                if (!s_reg.enable) begin
                    s_next.state = tpg_pkg::ST_IDLE;
                end else if (adv) begin
                    case (1'b1)
                        s_reg.select[tpg_pkg::SEL_PN7]: begin
                            d = pn_bits(s_reg.pn, 7, 7, 6);
                            s_next.pn = pn_step(s_reg.pn, 7, 7, 6);
                        end
                        s_reg.select[tpg_pkg::SEL_PN15]: begin
                            d = pn_bits(s_reg.pn, 15, 15, 14);
                            s_next.pn = pn_step(s_reg.pn, 15, 15, 14);
                        end
                        s_reg.select[tpg_pkg::SEL_PN23]: begin
                            d = pn_bits(s_reg.pn, 23, 23, 18);
                            s_next.pn = pn_step(s_reg.pn, 23, 23, 18);
                        end
                        s_reg.select[tpg_pkg::SEL_PN31]: begin
                            d = pn_bits(s_reg.pn, 31, 31, 28);
                            s_next.pn = pn_step(s_reg.pn, 31, 31, 28);
                        end
                        s_reg.select[tpg_pkg::SEL_HIGH_TOGGLE]: d = high_toggle();
                        s_reg.select[tpg_pkg::SEL_LOW_TOGGLE]: d = low_toggle();
                        default: d = high_toggle();
                    endcase
                end
            end
            default: s_next.state = tpg_pkg::ST_IDLE;
        endcase
        // Load a new beat; lost error if stopped early
        if (adv && s_reg.enable && s_reg.state != tpg_pkg::ST_IDLE) begin
            s_next.beat = d;
            s_next.beat[0] = d[0] ^ s_next.pend_err;
            s_next.beat_valid = 1'b1;
            s_next.pend_err = 1'b0;
        end
        if (!s_reg.enable && s_reg.state == tpg_pkg::ST_IDLE) begin
            s_next.pend_err = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_reg <= '0;
            s_reg.state <= tpg_pkg::ST_IDLE;
            s_reg.select <= 6'h01;
            s_reg.pn <= tpg_pkg::PN_SEED;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_read_data_o = s_reg.rdata;

    tpg_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(s_reg.beat_valid),
        .in_ready_o(fifo_ready),
        .in_data_i(s_reg.beat),
        .out_valid_o(src_valid_o),
        .out_ready_i(src_ready_i),
        .out_data_o(src_data_o)
    );
endmodule
`default_nettype wire

// ### tb/tpg_sink.sv
`default_nettype none
module tpg_sink #(
    parameter int DATA_W = 40
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Stream in
    input wire logic valid_i,
    input wire logic [DATA_W-1:0] data_i,
    output logic ready_o,
    // Pacing
    input wire logic stop_i,
    input wire logic slow_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic phase_reg;
    logic [DATA_W-1:0] beats[$];
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_reg <= 1'b0;
            ready_o <= 1'b0;
        end else begin
            if (valid_i && ready_o) begin
                beats.push_back(data_i);
            end
            phase_reg <= !phase_reg;
            ready_o <= #1 !stop_i && (!slow_i || phase_reg);
        end
    end
endmodule
`default_nettype wire

// ### tb/tpg_top_chk.sv
`default_nettype none
module tpg_chk #(
    parameter int DATA_W = 40,
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Register port
    input wire tpg_pkg::tpg_reg_req_t reg_req_i,
    input wire logic [31:0] reg_read_data_o,
    // Stream source
    input wire logic src_valid_o,
    input wire logic src_ready_i,
    input wire logic [DATA_W-1:0] src_data_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    logic en_reg;
    logic wr_en;
    assign wr_en = reg_req_i.write && reg_req_i.address == tpg_pkg::ADDR_ENABLE;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            en_reg <= 1'b0;
        end else if (wr_en) begin
            en_reg <= reg_req_i.write_data[0];
        end
    end
    sequence s_wr(a);
        reg_req_i.write && reg_req_i.address == a;
    endsequence
    sequence s_hold(a);
        !reg_req_i.write && reg_req_i.address == a && src_ready_i;
    endsequence
    chk_stall_hold: assert property (src_valid_o && !src_ready_i |=>
        src_valid_o && $stable(src_data_o)) else $error("beat changed under stall");
    chk_start_delay: assert property (s_wr(tpg_pkg::ADDR_ENABLE) ##0
        (reg_req_i.write_data[0] && !en_reg && !src_valid_o) |=> !src_valid_o [*3] ##1 src_valid_o)
        else $error("first beat not in fourth cycle");
    chk_drained_quiet: assert property (!en_reg && !$past(en_reg) && !wr_en && !src_valid_o
        |=> !src_valid_o) else $error("beat while disabled");
    chk_read_back: assert property (s_wr(tpg_pkg::ADDR_ENABLE) ##1 s_hold(tpg_pkg::ADDR_ENABLE)
        |=> reg_read_data_o[0] == $past(reg_req_i.write_data[0], 2)) else $error("enable readback");
    chk_locked_write: assert property (en_reg ##0 s_wr(tpg_pkg::ADDR_PATTERN)
        ##1 s_hold(tpg_pkg::ADDR_PATTERN) |=> $stable(reg_read_data_o)) else $error("locked write");
    chk_count_field: assert property (!en_reg ##0 s_wr(tpg_pkg::ADDR_PREAMBLE_CTRL)
        ##1 s_hold(tpg_pkg::ADDR_PREAMBLE_CTRL) |=>
        reg_read_data_o[15:8] == $past(reg_req_i.write_data[15:8], 2)) else $error("count field");
    chk_inject_clear: assert property (en_reg ##0 s_wr(tpg_pkg::ADDR_INJECT)
        ##1 s_hold(tpg_pkg::ADDR_INJECT) [*3] |=> !reg_read_data_o[0]) else $error("inject stuck");
    chk_unmapped_zero: assert property (reg_req_i.address > 3'h5 |=>
        reg_read_data_o == 32'h0) else $error("unmapped read not zero");
endmodule
`default_nettype wire
bind tpg_top tpg_chk #(.DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .reg_req_i(reg_req_i), .reg_read_data_o(reg_read_data_o),
    .src_valid_o(src_valid_o), .src_ready_i(src_ready_i), .src_data_o(src_data_o));

// ### tb/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = 40;
    localparam logic [W-1:0] HF = 40'hAAAAAAAAAA;
    localparam int LENS[4] = '{7, 15, 23, 31};
    localparam int TAPS[4] = '{6, 14, 18, 28};
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    tpg_pkg::tpg_reg_req_t req = '0;
    logic [31:0] rdata;
    logic valid;
    logic ready;
    logic stop = 1'b0;
    logic slow = 1'b0;
    logic [W-1:0] data;
    logic [31:0] d;
    int fail_count = 0;
    int total_checks = 0;
    always #20 clk_i = ~clk_i;
    tpg_top #(.DATA_W(W), .FIFO_DEPTH(16)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .reg_req_i(req), .reg_read_data_o(rdata), .src_valid_o(valid), .src_ready_i(ready),
        .src_data_o(data));
    tpg_sink #(.DATA_W(W)) u_sink (.clk_i(clk_i), .rst_b_i(rst_b_i), .valid_i(valid),
        .data_i(data), .ready_o(ready), .stop_i(stop), .slow_i(slow));
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [31:0] v);
        step(1);
        req.write = 1'b1;
        req.address = a;
        req.write_data = v;
        step(1);
        req.write = 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        step(1);
        req.address = a;
        step(1);
        d = rdata;
    endtask
    task automatic collect(input int n);
        int k = 0;
        while (u_sink.beats.size() < n && k < 2000) begin
            step(1);
            k++;
        end
    endtask
    task automatic start(input int sel);
        int n = 1;
        wr(tpg_pkg::ADDR_PATTERN, 32'h1 << sel);
        u_sink.beats.delete();
        wr(tpg_pkg::ADDR_ENABLE, 32'h1);
        while (valid !== 1'b1 && n < 20) begin
            step(1);
            n++;
        end
        chk("start cycle", W'(4), W'(n));
    endtask
    task automatic stop_gen();
        int n;
        wr(tpg_pkg::ADDR_ENABLE, 32'h0);
        rd(tpg_pkg::ADDR_ENABLE);
        chk("enable readback", '0, W'(d));
        step(40);
        n = u_sink.beats.size();
        step(10);
        chk("beats after stop", W'(n), W'(u_sink.beats.size()));
    endtask
    task automatic pn_check(input int len, input int tap);
        logic [2*W-1:0] s;
        int bad = 0;
        for (int b = 0; b + 1 < u_sink.beats.size(); b++) begin
            s = {u_sink.beats[b], u_sink.beats[b+1]};
            for (int j = 0; j < 2 * W - len; j++) begin
                bad += int'(s[j] !== (s[j+tap] ^ s[j+len]));
            end
        end
        chk("pn recurrence errors", '0, W'(bad));
    endtask
    task automatic t_regs();
        rd(tpg_pkg::ADDR_PATTERN);
        chk("select reset", W'(1), W'(d[5:0]));
        rd(tpg_pkg::ADDR_PREAMBLE_CTRL);
        chk("repeat count reset", '0, W'(d[15:8]));
        rd(3'h6);
        chk("unmapped read", '0, W'(d));
        wr(tpg_pkg::ADDR_PREAMBLE_CTRL, 32'h0000FF00);
        rd(tpg_pkg::ADDR_PREAMBLE_CTRL);
        chk("repeat count max", W'(8'hFF), W'(d[15:8]));
    endtask
    task automatic t_preamble();
        wr(tpg_pkg::ADDR_CHAR_LOW, 32'h12345678);
        rd(tpg_pkg::ADDR_CHAR_LOW);
        chk("char low", W'(32'h12345678), W'(d));
        wr(tpg_pkg::ADDR_CHAR_HIGH, 32'h0000009A);
        rd(tpg_pkg::ADDR_CHAR_HIGH);
        chk("char high", W'(8'h9A), W'(d[7:0]));
        wr(tpg_pkg::ADDR_PREAMBLE_CTRL, 32'h00000301);
        start(4);
        collect(5);
        stop_gen();
        for (int b = 0; b < 5; b++) begin
            chk("preamble stream", b < 3 ? 40'h9A12345678 : HF, u_sink.beats[b]);
        end
        wr(tpg_pkg::ADDR_PREAMBLE_CTRL, 32'h0);
    endtask
    task automatic t_patterns();
        for (int sel = 0; sel < 6; sel++) begin
            start(sel);
            collect(4);
            stop_gen();
            if (sel < 4) begin
                pn_check(LENS[sel], TAPS[sel]);
            end else begin
                foreach (u_sink.beats[b]) begin
                    chk("toggle beat", sel == 4 ? HF : 40'hF83E0F83E0, u_sink.beats[b]);
                end
            end
        end
    endtask
    task automatic t_inject();
        int hits = 0;
        wr(tpg_pkg::ADDR_INJECT, 32'h1);
        start(4);
        collect(6);
        chk("first beat", HF ^ 40'h1, u_sink.beats[0]);
        wr(tpg_pkg::ADDR_INJECT, 32'h1);
        rd(tpg_pkg::ADDR_INJECT);
        rd(tpg_pkg::ADDR_INJECT);
        chk("inject self clear", '0, W'(d[0]));
        wr(tpg_pkg::ADDR_PATTERN, 32'h20);
        rd(tpg_pkg::ADDR_PATTERN);
        chk("locked select", W'(6'h10), W'(d[5:0]));
        stop_gen();
        foreach (u_sink.beats[b]) begin
            hits += int'(u_sink.beats[b] === (HF ^ 40'h1));
        end
        chk("flipped beats", W'(2), W'(hits));
    endtask
    task automatic t_stall();
        stop = 1'b1;
        start(0);
        step(40);
        chk("beats under stall", '0, W'(u_sink.beats.size()));
        slow = 1'b1;
        stop = 1'b0;
        collect(24);
        slow = 1'b0;
        stop_gen();
        pn_check(7, 6);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #800000;
        fail_count++;
        $display("ERROR watchdog expected end seen timeout");
        results();
    end
    initial begin
        step(6);
        rst_b_i = 1'b1;
        t_regs();
        t_preamble();
        t_patterns();
        t_inject();
        t_stall();
        results();
    end
endmodule
`default_nettype wire
